// File: hw/usb_status_map.svh
// register offsets, field positions, reset values and timing counts for the usb status block
`ifndef USB_STATUS_MAP_SVH
`define USB_STATUS_MAP_SVH
`define OFF_BUS_EVENT 12'h140
`define OFF_IRQ_MASK 12'h144
`define OFF_IRQ_STATUS 12'h148
`define OFF_DEV_CTRL 12'h100
`define OFF_ZLP_RX 12'h150
`define OFF_ZLP_TX 12'h154
`define OFF_SEND_ZLP 12'h15C
`define BIT_BUS_RESET 0
`define BIT_SUSPEND 1
`define BIT_GO_SUSPEND 0
`define IRQ_BIT_ZLP_RX 2
`define IRQ_BIT_ZLP_TX 3
`define RESET_FLAGS 8'h00
`define RESET_EVENTS 2'h0
`define IRQ_WIDTH 4
`define CLK_MHZ 125
`define SUSPEND_IDLE_US 3000
`define SUSPEND_IDLE_CYCLES (`SUSPEND_IDLE_US * `CLK_MHZ)
`endif

// File: hw/usb_status_pkg.sv
// types shared by the usb status block
package usb_status_pkg;
    typedef logic [7:0] ep_flags_t;
    typedef logic [31:0] word_t;
    typedef enum logic [2:0] {
        IDLE_ACTIVE = 3'b001,
        IDLE_COUNT = 3'b010,
        IDLE_SUSPENDED = 3'b100
    } idle_state_t;
endpackage

// File: hw/ep_flag_bank.sv
// eight per-endpoint sticky status flags, software writes the whole byte
`timescale 1ns/1ps
`include "usb_status_map.svh"
module ep_flag_bank (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // hardware events, one bit per endpoint
    input wire usb_status_pkg::ep_flags_t setPulse,
    // software write
    input wire logic writeEn,
    input wire usb_status_pkg::ep_flags_t writeData,
    // stored flags
    output usb_status_pkg::ep_flags_t flags
);
    usb_status_pkg::ep_flags_t flags_r; // held flags
    usb_status_pkg::ep_flags_t flags_nxt; // next value
    // a set in the same cycle as a write of zero still wins, so no event is lost
    assign flags_nxt = (writeEn ? writeData : flags_r) | setPulse;
    assign flags = flags_r;
    // flag storage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_r <= `RESET_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end
endmodule

// File: hw/idle_timer.sv
// bus idle timer: flags the moment the line has been idle beyond the suspend limit
`timescale 1ns/1ps
`include "usb_status_map.svh"
module idle_timer #(
    parameter int unsigned IDLE_CYCLES = `SUSPEND_IDLE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // line state
    input wire logic busIdle,
    // one-cycle pulse once idle exceeds the limit
    output logic idleExpired
);
    usb_status_pkg::idle_state_t state_r; // timer state
    usb_status_pkg::idle_state_t state_nxt; // next state
    logic [19:0] count_r; // idle cycles seen
    logic [19:0] count_nxt; // next count
    wire logic atLimit; // count has reached the limit
    // strictly more than the limit, hence the compare with the limit itself
    assign atLimit = count_r >= 20'(IDLE_CYCLES);
    // next state and counter
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        idleExpired = 1'b0;
        unique case (state_r)
            usb_status_pkg::IDLE_ACTIVE: begin
                count_nxt = 20'h00000;
                if (busIdle) begin
                    state_nxt = usb_status_pkg::IDLE_COUNT;
                end
            end
            usb_status_pkg::IDLE_COUNT: begin
                if (!busIdle) begin
                    state_nxt = usb_status_pkg::IDLE_ACTIVE;
                end else if (atLimit) begin
                    idleExpired = 1'b1;
                    state_nxt = usb_status_pkg::IDLE_SUSPENDED;
                end else begin
                    count_nxt = count_r + 20'h00001;
                end
            end
            usb_status_pkg::IDLE_SUSPENDED: begin
                // one pulse per idle stretch; wait for activity
                if (!busIdle) begin
                    state_nxt = usb_status_pkg::IDLE_ACTIVE;
                end
            end
            default: begin
                state_nxt = usb_status_pkg::IDLE_ACTIVE;
            end
        endcase
    end
    // state registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= usb_status_pkg::IDLE_ACTIVE;
            count_r <= 20'h00000;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
        end
    end
endmodule

// File: hw/usb_device_bus_event_zlp_status.sv
// usb device bus event and zero-length packet status registers behind an ahb-lite slave
// Summary of operation
// - idle over 3 ms sets suspend flag
// - bus reset or resume clears suspend
// - suspend flag bit 1, write-one clears
// - bus reset sets bit 0 flag
// - received zero-length packet sets rx flag
// - eight rx flags, endpoints one to eight
// - sent zero-length packet sets tx flag
// - tx flag n at bit n-1
// - zero-length sent clears send request
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`include "usb_status_map.svh"
module usb_device_bus_event_zlp_status #(
    parameter int unsigned IDLE_CYCLES = `SUSPEND_IDLE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // usb link events from the protocol engine
    input wire logic busIdle,
    input wire logic busResetDetect,
    input wire logic resumeDetect,
    input wire usb_status_pkg::ep_flags_t epZeroLenRx,
    input wire usb_status_pkg::ep_flags_t epZeroLenTx,
    // control toward the protocol engine
    output logic goSuspendRequest,
    output usb_status_pkg::ep_flags_t inEpSendZeroLenRequest,
    // interrupt
    output logic irq
);
    // address phase capture
    logic wrPend_r; // write data phase pending
    logic [11:0] addr_r; // latched byte address, low 12 bits
    wire logic addrTaken; // valid transfer accepted
    assign addrTaken = hsel & hready & htrans[1];
    // address phase register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            addr_r <= 12'h000;
        end else begin
            wrPend_r <= addrTaken & hwrite;
            addr_r <= addrTaken ? haddr[11:0] : addr_r;
        end
    end
    // the slave never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // write decode, done in the data phase when hwdata is valid
    wire logic wrBusEvent; // write to bus event flags
    wire logic wrMask; // write to interrupt mask
    wire logic wrCtrl; // write to device control
    wire logic wrRx; // write to rx status
    wire logic wrTx; // write to tx status
    wire logic wrSendZlp; // write to send request register
    assign wrBusEvent = wrPend_r & (addr_r == `OFF_BUS_EVENT);
    assign wrMask = wrPend_r & (addr_r == `OFF_IRQ_MASK);
    assign wrCtrl = wrPend_r & (addr_r == `OFF_DEV_CTRL);
    assign wrRx = wrPend_r & (addr_r == `OFF_ZLP_RX);
    assign wrTx = wrPend_r & (addr_r == `OFF_ZLP_TX);
    assign wrSendZlp = wrPend_r & (addr_r == `OFF_SEND_ZLP);

    // read decode in the address phase so data is registered for the data phase
    wire logic rdTaken; // read accepted this cycle
    wire logic rdIrqStatus; // read of interrupt status clears it
    assign rdTaken = addrTaken & ~hwrite;
    assign rdIrqStatus = rdTaken & (haddr[11:0] == `OFF_IRQ_STATUS);

    // suspend idle timer
    wire logic idleExpired; // idle limit reached
    idle_timer #(
        .IDLE_CYCLES(IDLE_CYCLES)
    ) u_idle_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .busIdle(busIdle),
        .idleExpired(idleExpired)
    );

    // bus event flags: bit 0 bus reset, bit 1 suspend
    logic suspendEventFlag_r; // suspend flag
    logic suspendEventFlag_nxt; // next suspend flag
    logic busResetEventFlag_r; // bus reset flag
    logic busResetEventFlag_nxt; // next bus reset flag
    wire logic clrSuspendSw; // write-one clear of suspend
    wire logic clrBusResetSw; // write-one clear of bus reset
    assign clrSuspendSw = wrBusEvent & hwdata[`BIT_SUSPEND];
    assign clrBusResetSw = wrBusEvent & hwdata[`BIT_BUS_RESET];
    // suspend: expiry wins over any clear; bus reset or resume also clear it
    assign suspendEventFlag_nxt = idleExpired
        | (suspendEventFlag_r & ~clrSuspendSw & ~busResetDetect & ~resumeDetect);
    // bus reset: only a firmware write clears it
    assign busResetEventFlag_nxt = busResetDetect | (busResetEventFlag_r & ~clrBusResetSw);
    // bus event flag storage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            suspendEventFlag_r <= 1'b0;
            busResetEventFlag_r <= 1'b0;
        end else begin
            suspendEventFlag_r <= suspendEventFlag_nxt;
            busResetEventFlag_r <= busResetEventFlag_nxt;
        end
    end

    // device control: go-suspend request
    logic goSuspend_r; // go-suspend bit
    // firmware is expected to clear the suspend flag first; hardware does not check
    // leaving suspend on resume or bus reset drops the request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            goSuspend_r <= 1'b0;
        end else if (busResetDetect | resumeDetect) begin
            goSuspend_r <= 1'b0;
        end else if (wrCtrl) begin
            goSuspend_r <= hwdata[`BIT_GO_SUSPEND];
        end
    end
    assign goSuspendRequest = goSuspend_r;

    // per endpoint zero-length status banks
    usb_status_pkg::ep_flags_t zeroLengthReceiveStatus; // rx flags, endpoint n at bit n-1
    usb_status_pkg::ep_flags_t zeroLengthTransmitStatus; // tx flags, endpoint n at bit n-1
    ep_flag_bank u_rx_bank (
        .ref_clk(ref_clk),
        .rst(rst),
        .setPulse(epZeroLenRx),
        .writeEn(wrRx),
        .writeData(hwdata[7:0]),
        .flags(zeroLengthReceiveStatus)
    );
    ep_flag_bank u_tx_bank (
        .ref_clk(ref_clk),
        .rst(rst),
        .setPulse(epZeroLenTx),
        .writeEn(wrTx),
        .writeData(hwdata[7:0]),
        .flags(zeroLengthTransmitStatus)
    );

    // send zero-length request bits, one per in endpoint
    usb_status_pkg::ep_flags_t sendZlp_r; // request bits
    usb_status_pkg::ep_flags_t sendZlp_nxt; // next request bits
    // the sent event clears its bit even against a same-cycle write of one
    assign sendZlp_nxt = (wrSendZlp ? hwdata[7:0] : sendZlp_r) & ~epZeroLenTx;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sendZlp_r <= `RESET_FLAGS;
        end else begin
            sendZlp_r <= sendZlp_nxt;
        end
    end
    assign inEpSendZeroLenRequest = sendZlp_r;

    // interrupt status: sticky, cleared by reading it
    logic [`IRQ_WIDTH-1:0] irqStatus_r; // sticky events
    logic [`IRQ_WIDTH-1:0] irqStatus_nxt; // next sticky events
    logic [`IRQ_WIDTH-1:0] irqMask_r; // enable mask, one enables
    wire logic [`IRQ_WIDTH-1:0] irqEvents; // this cycle's events
    assign irqEvents = {|epZeroLenTx, |epZeroLenRx, idleExpired, busResetDetect};
    // an event in the cycle of the clearing read survives
    assign irqStatus_nxt = (rdIrqStatus ? {`IRQ_WIDTH{1'b0}} : irqStatus_r) | irqEvents;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irqStatus_r <= {`IRQ_WIDTH{1'b0}};
            irqMask_r <= {`IRQ_WIDTH{1'b0}};
        end else begin
            irqStatus_r <= irqStatus_nxt;
            irqMask_r <= wrMask ? hwdata[`IRQ_WIDTH-1:0] : irqMask_r;
        end
    end
    assign irq = |(irqStatus_r & irqMask_r);

    // read mux, unmapped and reserved bits read as zero
    wire logic [11:0] rdAddr; // address being read
    usb_status_pkg::word_t rdMux; // selected word
    assign rdAddr = haddr[11:0];
    assign rdMux =
        (rdAddr == `OFF_BUS_EVENT) ? {30'h00000000, suspendEventFlag_r, busResetEventFlag_r} :
        (rdAddr == `OFF_IRQ_MASK) ? {28'h0000000, irqMask_r} :
        (rdAddr == `OFF_IRQ_STATUS) ? {28'h0000000, irqStatus_r} :
        (rdAddr == `OFF_DEV_CTRL) ? {31'h00000000, goSuspend_r} :
        (rdAddr == `OFF_ZLP_RX) ? {24'h000000, zeroLengthReceiveStatus} :
        (rdAddr == `OFF_ZLP_TX) ? {24'h000000, zeroLengthTransmitStatus} :
        (rdAddr == `OFF_SEND_ZLP) ? {24'h000000, sendZlp_r} :
        32'h00000000;
    // read data register; holds between reads
    logic [31:0] hrdata_r; // registered read data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hrdata_r <= 32'h00000000;
        end else if (rdTaken) begin
            hrdata_r <= rdMux;
        end
    end
    assign hrdata = hrdata_r;
endmodule

// File: test/usb_status_asserts.sv
// port checker for the usb status block
`timescale 1ns/1ps
`include "usb_status_map.svh"
module usb_status_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // link side
    input wire logic busIdle,
    input wire logic busResetDetect,
    input wire logic resumeDetect,
    input wire usb_status_pkg::ep_flags_t epZeroLenTx,
    input wire usb_status_pkg::ep_flags_t epZeroLenRx,
    input wire logic goSuspendRequest,
    input wire usb_status_pkg::ep_flags_t inEpSendZeroLenRequest
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // read address phases of the watched registers
    wire logic take = hsel && hready && htrans[1];
    wire logic rdRx = take && !hwrite && haddr[11:0] == `OFF_ZLP_RX;
    wire logic rdTx = take && !hwrite && haddr[11:0] == `OFF_ZLP_TX;
    wire logic rdEv = take && !hwrite && haddr[11:0] == `OFF_BUS_EVENT;
    wire logic link = busResetDetect || resumeDetect;
    // write data phase: a write landing here may legally clear a fresh flag
    logic wrPh_r;
    always_ff @(posedge ref_clk) begin
        wrPh_r <= take && hwrite && !rst;
    end
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_rx_reserved: assert property (rdRx |=> hrdata[31:8] == 24'h000000)
        else $error("rx reserved bits set");
    a_tx_reserved: assert property (rdTx |=> hrdata[31:8] == 24'h000000)
        else $error("tx reserved bits set");
    a_rx_sets: assert property ((epZeroLenRx != 8'h00) ##1 !wrPh_r ##1 (rdRx && !wrPh_r) |=>
        (hrdata[7:0] & $past(epZeroLenRx, 3)) == $past(epZeroLenRx, 3)) else $error("rx flag missing");
    a_tx_sets: assert property ((epZeroLenTx != 8'h00) ##1 !wrPh_r ##1 (rdTx && !wrPh_r) |=>
        (hrdata[7:0] & $past(epZeroLenTx, 3)) == $past(epZeroLenTx, 3)) else $error("tx flag missing");
    a_busrst_sets: assert property (busResetDetect ##1 !wrPh_r ##1 (rdEv && !wrPh_r) |=> hrdata[0])
        else $error("bus reset flag missing");
    a_susp_clear: assert property ((link && !busIdle && !$past(busIdle)) ##1 !busIdle ##1
        (rdEv && !wrPh_r && !busIdle) |=> !hrdata[1]) else $error("suspend flag not cleared");
    a_sendreq_clear: assert property ((epZeroLenTx != 8'h00) |=>
        (inEpSendZeroLenRequest & $past(epZeroLenTx)) == 8'h00) else $error("send request kept");
    a_go_suspend_request_drop: assert property (link |=> !goSuspendRequest) else $error("go-suspend kept");
endmodule
bind usb_device_bus_event_zlp_status usb_status_asserts chk (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .busIdle(busIdle), .busResetDetect(busResetDetect), .resumeDetect(resumeDetect),
    .epZeroLenTx(epZeroLenTx), .epZeroLenRx(epZeroLenRx), .goSuspendRequest(goSuspendRequest),
    .inEpSendZeroLenRequest(inEpSendZeroLenRequest));

// File: test/usb_host_model.sv
// usb host side model: line idle and one-cycle link events
`timescale 1ns/1ps
module usb_host_model (
    // clock
    input wire logic ref_clk,
    // link events toward the device
    output logic busIdle,
    output logic busResetDetect,
    output logic resumeDetect,
    output usb_status_pkg::ep_flags_t epZeroLenRx,
    output usb_status_pkg::ep_flags_t epZeroLenTx
);
    // traffic on the line, nothing pending
    initial begin
        busIdle = 1'b0;
        busResetDetect = 1'b0;
        resumeDetect = 1'b0;
        epZeroLenRx = 8'h00;
        epZeroLenTx = 8'h00;
    end
    // hold the line idle n cycles, then traffic; the gap keeps link events off the expiry edge
    task automatic idle(input int n);
        busIdle <= 1'b1;
        repeat (n) @(posedge ref_clk);
        busIdle <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    // one-cycle pulses of reset, resume and zero-length packets
    task automatic pulse(input logic r, input logic s, input usb_status_pkg::ep_flags_t rx,
        input usb_status_pkg::ep_flags_t tx);
        busResetDetect <= r;
        resumeDetect <= s;
        epZeroLenRx <= rx;
        epZeroLenTx <= tx;
        @(posedge ref_clk);
        busResetDetect <= 1'b0;
        resumeDetect <= 1'b0;
        epZeroLenRx <= 8'h00;
        epZeroLenTx <= 8'h00;
        @(posedge ref_clk);
    endtask
endmodule

// File: test/usb_device_bus_event_zlp_status_test.sv
// self-checking bench for the usb status block
`timescale 1ns/1ps
`include "usb_status_map.svh"
module usb_device_bus_event_zlp_status_test;
    localparam int unsigned IDLE = 20; // short suspend count keeps the run brief
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    // bus master side
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, busIdle, busResetDetect, resumeDetect, goSuspendRequest, irq;
    usb_status_pkg::ep_flags_t epZeroLenRx, epZeroLenTx, inEpSendZeroLenRequest;
    usb_status_pkg::word_t q;
    int errors = 0;
    int n_compared = 0;
    // ordinary cases: events on both banks and the words they give
    typedef struct {logic [7:0] rx; logic [7:0] tx; logic [31:0] rxExp; logic [31:0] txExp;} row_t;
    row_t rows [4] = '{'{8'h01, 8'h80, 32'h01, 32'h80}, '{8'h80, 8'h01, 32'h80, 32'h01},
        '{8'h55, 8'hAA, 32'h55, 32'hAA}, '{8'hFF, 8'hFF, 32'hFF, 32'hFF}};
    always #4 ref_clk = ~ref_clk;
    usb_device_bus_event_zlp_status #(.IDLE_CYCLES(IDLE)) DUT (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busIdle(busIdle),
        .busResetDetect(busResetDetect), .resumeDetect(resumeDetect), .epZeroLenRx(epZeroLenRx),
        .epZeroLenTx(epZeroLenTx), .goSuspendRequest(goSuspendRequest),
        .inEpSendZeroLenRequest(inEpSendZeroLenRequest), .irq(irq));
    usb_host_model host (.ref_clk(ref_clk), .busIdle(busIdle), .busResetDetect(busResetDetect),
        .resumeDetect(resumeDetect), .epZeroLenRx(epZeroLenRx), .epZeroLenTx(epZeroLenTx));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one single ahb transfer, entered just after a rising edge
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        q = hrdata;
    endtask
    // read and compare
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // verdict, reached from the main sequence or the watchdog
    task automatic results();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (4000) @(posedge ref_clk);
        errors++;
        results();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // table: sticky per-endpoint flags, cleared by writing zero
        foreach (rows[i]) begin
            host.pulse(1'b0, 1'b0, rows[i].rx, rows[i].tx);
            rd(`OFF_ZLP_RX, rows[i].rxExp);
            rd(`OFF_ZLP_TX, rows[i].txExp);
            ahb(1'b1, `OFF_ZLP_RX, 32'h0);
            ahb(1'b1, `OFF_ZLP_TX, 32'h0);
            rd(`OFF_ZLP_RX, 32'h0);
        end
        // rw flags with reserved bits dropped, unmapped place ignored
        ahb(1'b1, `OFF_ZLP_RX, 32'hFFFFFF5A);
        rd(`OFF_ZLP_RX, 32'h5A);
        ahb(1'b1, 12'h1F0, 32'hFFFFFFFF);
        rd(12'h1F0, 32'h0);
        // bus reset flag stays until firmware writes one
        host.pulse(1'b1, 1'b0, 8'h00, 8'h00);
        rd(`OFF_BUS_EVENT, 32'h1);
        rd(`OFF_BUS_EVENT, 32'h1);
        ahb(1'b1, `OFF_BUS_EVENT, 32'h1);
        rd(`OFF_BUS_EVENT, 32'h0);
        // suspend: short idle no, long idle yes, resume and bus reset clear it
        host.idle(IDLE - 5);
        rd(`OFF_BUS_EVENT, 32'h0);
        host.idle(IDLE + 10);
        rd(`OFF_BUS_EVENT, 32'h2);
        host.pulse(1'b0, 1'b1, 8'h00, 8'h00);
        rd(`OFF_BUS_EVENT, 32'h0);
        host.idle(IDLE + 10);
        ahb(1'b1, `OFF_BUS_EVENT, 32'h2);
        rd(`OFF_BUS_EVENT, 32'h0);
        host.idle(IDLE + 10);
        host.pulse(1'b1, 1'b0, 8'h00, 8'h00);
        rd(`OFF_BUS_EVENT, 32'h1);
        // send request dropped by the zero-length packet sent on endpoint 3
        ahb(1'b1, `OFF_SEND_ZLP, 32'hFF);
        host.pulse(1'b0, 1'b0, 8'h00, 8'h04);
        rd(`OFF_SEND_ZLP, 32'hFB);
        chk({24'h0, inEpSendZeroLenRequest}, 32'hFB);
        // interrupt: drain status, masked event quiet, unmasked raises, read clears
        ahb(1'b0, `OFF_IRQ_STATUS, 32'h0);
        ahb(1'b1, `OFF_IRQ_MASK, 32'h4);
        host.pulse(1'b0, 1'b0, 8'h00, 8'h01);
        chk({31'h0, irq}, 32'h0);
        host.pulse(1'b0, 1'b0, 8'h02, 8'h00);
        chk({31'h0, irq}, 32'h1);
        rd(`OFF_IRQ_STATUS, 32'hC);
        chk({31'h0, irq}, 32'h0);
        // go-suspend after suspend flag is clear, dropped by resume
        ahb(1'b1, `OFF_DEV_CTRL, 32'h1);
        @(posedge ref_clk);
        chk({31'h0, goSuspendRequest}, 32'h1);
        host.pulse(1'b0, 1'b1, 8'h00, 8'h00);
        chk({31'h0, goSuspendRequest}, 32'h0);
        // second reset in mid-run brings every flag back to zero
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(`OFF_ZLP_RX, 32'h0);
        rd(`OFF_ZLP_TX, 32'h0);
        rd(`OFF_BUS_EVENT, 32'h0);
        results();
    end
endmodule
